// ---- sfxmc_pkg.sv ----
// Purpose: shared constants and types of the execute-in-place flash host controller
// Assumes: 100 MHz system clock, flash clock made here by a divider
// Notes:   flash opcodes and own register offsets are plain defaults

package sfxmc_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses on the apb side)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_CFG    = 8'h04;
	localparam logic [7:0] ADDR_FADDR  = 8'h08;
	localparam logic [7:0] ADDR_VOLCFG = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_RDATA  = 8'h14;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_OP_LSB    = 0;
	localparam int CTRL_GO_BIT    = 4;
	localparam int CFG_WIDTH_LSB  = 0;
	localparam int CFG_DUMMY_LSB  = 4;
	localparam int CFG_BASIC_BIT  = 8;
	localparam int CFG_EXIT_BIT   = 9;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_EIP_BIT   = 1;
	localparam int STAT_ARMED_BIT = 2;
	localparam int VOLCFG_EIP_BIT = 3;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [1:0] WIDTH_RST  = 2'h0;
	localparam logic [3:0] DUMMY_RST  = 4'h8;
	localparam logic [7:0] VOLCFG_RST = 8'hf7;

	// ------------------------------------------------------------
	// flash opcodes and frame lengths
	// ------------------------------------------------------------
	localparam logic [7:0] OPC_WR_ENABLE = 8'h06;
	localparam logic [7:0] OPC_WR_VOLCFG = 8'h81;
	localparam logic [7:0] OPC_FREAD_1   = 8'h0b;
	localparam logic [7:0] OPC_FREAD_2   = 8'hbb;
	localparam logic [7:0] OPC_FREAD_4   = 8'heb;
	localparam logic [5:0] ADDR_BITS     = 6'h18;
	localparam logic [5:0] BYTE_BITS     = 6'h08;
	localparam logic [5:0] BURST_A       = 6'h07;
	localparam logic [5:0] BURST_B       = 6'h0d;
	localparam logic [5:0] BURST_C       = 6'h19;
	localparam logic [5:0] BURST_PWR     = 6'h08;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int         CLK_NS        = 10;
	localparam int         DESEL_NS      = 50;
	localparam int         RST_PULSE_NS  = 100;
	localparam logic [7:0] DESEL_CYC     = 8'((DESEL_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RST_PULSE_CYC = 8'((RST_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] SCLK_HALF_CYC = 4'h4;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {OP_NOP = 3'h0, OP_ARM = 3'h1, OP_READ = 3'h2, OP_EXIT3 = 3'h3,
		OP_PWRFIX = 3'h4, OP_RSTPIN = 3'h5} sfxmc_op_t;
	typedef enum logic [2:0] {SG_OPC = 3'h0, SG_ADDR = 3'h1, SG_DUMMY = 3'h2, SG_DATA = 3'h3,
		SG_BURST = 3'h4} sfxmc_seg_t;
	typedef enum logic [2:0] {ST_BOOT = 3'b000, ST_IDLE = 3'b001, ST_LOAD = 3'b011, ST_SHIFT = 3'b010,
		ST_DESEL = 3'b110, ST_RSTP = 3'b111} sfxmc_state_t;

endpackage

// ---- sfxmc_core_if.sv ----
// Purpose: carries orders and status between register slave and flash engine
// Assumes: single clock domain
// Notes:   go is a one-cycle pulse

`timescale 1ns/1ps

interface sfxmc_core_if;
	logic                  go;
	sfxmc_pkg::sfxmc_op_t  op;
	logic [1:0]            width;
	logic [3:0]            dummy;
	logic                  basic;
	logic                  exit_req;
	logic [23:0]           addr;
	logic [7:0]            vol_cfg;
	logic                  busy;
	logic                  eip_on;
	logic                  armed;
	logic [7:0]            rdata;

	modport regs (output go, op, width, dummy, basic, exit_req, addr, vol_cfg,
		input busy, eip_on, armed, rdata);
	modport core (input go, op, width, dummy, basic, exit_req, addr, vol_cfg,
		output busy, eip_on, armed, rdata);
endinterface

// ---- sfxmc_sclk_div.sv ----
// Purpose: makes the flash clock from the system clock, mode 0 (idles low)
// Assumes: run stays high for whole clock periods
// Notes:   rise and fall are one-cycle pulses before the registered edge

`timescale 1ns/1ps

module sfxmc_sclk_div
(
	// clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// control
	input  wire logic run,
	// clock out and edge marks
	output logic      sclk,
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       lvl;
	} sfxmc_div_t;

	sfxmc_div_t r;
	sfxmc_div_t n;
	logic       wrap;

	assign wrap = run && (r.cnt == sfxmc_pkg::SCLK_HALF_CYC - 4'h1);
	assign rise = wrap && !r.lvl;
	assign fall = wrap && r.lvl;
	assign sclk = r.lvl;

	always_comb
	begin
		n = r;
		if (!run)
			n = '0;
		else if (wrap)
		begin
			n.cnt = 4'h0;
			n.lvl = !r.lvl;
		end
		else
			n.cnt = r.cnt + 4'h1;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			r <= '0;
		else
			r <= n;
	end
endmodule // sfxmc_sclk_div

// ---- sfxmc_apb_regs.sv ----
// Purpose: apb slave holding the controller's own order and status registers
// Assumes: zero wait states, 32-bit data, one word per register
// Notes:   unmapped offsets answer with pslverr and read zero

`timescale 1ns/1ps

module sfxmc_apb_regs
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// engine side
	sfxmc_core_if.regs       cif
);
	typedef struct packed {
		sfxmc_pkg::sfxmc_op_t op;
		logic                 go;
		logic [1:0]           width;
		logic [3:0]           dummy;
		logic                 basic;
		logic                 exit_req;
		logic [23:0]          addr;
		logic [7:0]           vol_cfg;
	} sfxmc_regs_t;

	localparam sfxmc_regs_t REGS_RST = '{op: sfxmc_pkg::OP_NOP, go: 1'b0, width: sfxmc_pkg::WIDTH_RST,
		dummy: sfxmc_pkg::DUMMY_RST, basic: 1'b0, exit_req: 1'b0, addr: 24'h000000,
		vol_cfg: sfxmc_pkg::VOLCFG_RST};

	sfxmc_regs_t r;
	sfxmc_regs_t n;
	logic        acc;
	logic        hit;
	logic [31:0] rd;

	assign acc     = psel && penable;
	assign pready  = 1'b1;
	assign pslverr = acc && !hit;
	assign prdata  = (acc && !pwrite) ? rd : 32'h00000000;

	assign cif.go       = r.go;
	assign cif.op       = r.op;
	assign cif.width    = r.width;
	assign cif.dummy    = r.dummy;
	assign cif.basic    = r.basic;
	assign cif.exit_req = r.exit_req;
	assign cif.addr     = r.addr;
	assign cif.vol_cfg  = r.vol_cfg;

	always_comb
	begin
		n = r;
		n.go = 1'b0;
		hit = 1'b1;
		rd = 32'h00000000;
		case (paddr)
			sfxmc_pkg::ADDR_CTRL:
				rd[sfxmc_pkg::CTRL_OP_LSB +: 3] = r.op;
			sfxmc_pkg::ADDR_CFG:
			begin
				rd[sfxmc_pkg::CFG_WIDTH_LSB +: 2] = r.width;
				rd[sfxmc_pkg::CFG_DUMMY_LSB +: 4] = r.dummy;
				rd[sfxmc_pkg::CFG_BASIC_BIT] = r.basic;
				rd[sfxmc_pkg::CFG_EXIT_BIT] = r.exit_req;
			end
			sfxmc_pkg::ADDR_FADDR:
				rd[23:0] = r.addr;
			sfxmc_pkg::ADDR_VOLCFG:
				rd[7:0] = r.vol_cfg;
			sfxmc_pkg::ADDR_STATUS:
			begin
				rd[sfxmc_pkg::STAT_BUSY_BIT] = cif.busy;
				rd[sfxmc_pkg::STAT_EIP_BIT] = cif.eip_on;
				rd[sfxmc_pkg::STAT_ARMED_BIT] = cif.armed;
			end
			sfxmc_pkg::ADDR_RDATA:
				rd[7:0] = cif.rdata;
			default:
				hit = 1'b0;
		endcase
		if (acc && pwrite)
		begin
			case (paddr)
				sfxmc_pkg::ADDR_CTRL:
					if (!cif.busy)
					begin
						n.op = sfxmc_pkg::sfxmc_op_t'(pwdata[sfxmc_pkg::CTRL_OP_LSB +: 3]);
						n.go = pwdata[sfxmc_pkg::CTRL_GO_BIT];
					end
				sfxmc_pkg::ADDR_CFG:
				begin
					n.width = pwdata[sfxmc_pkg::CFG_WIDTH_LSB +: 2];
					n.dummy = pwdata[sfxmc_pkg::CFG_DUMMY_LSB +: 4];
					n.basic = pwdata[sfxmc_pkg::CFG_BASIC_BIT];
					n.exit_req = pwdata[sfxmc_pkg::CFG_EXIT_BIT];
				end
				sfxmc_pkg::ADDR_FADDR:
					n.addr = pwdata[23:0];
				sfxmc_pkg::ADDR_VOLCFG:
					n.vol_cfg = pwdata[7:0];
				default:
					n.go = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			r <= REGS_RST;
		else
			r <= n;
	end
endmodule // sfxmc_apb_regs

// ---- sfxmc_top.sv ----
// Purpose: host controller that drives a multi-line serial flash in and out of execute-in-place reads
// Assumes: flash in clock mode 0, pull-ups on the flash data lines, apb software master
// Notes:   one order at a time; orders arriving while busy are dropped
//
// Register access over APB and the address map are this design's own decisions.

`timescale 1ns/1ps

module sfxmc_top
#(
	parameter bit RST_PIN_USED = 1'b0
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// flash pins
	output logic             flash_sclk,
	output logic             flash_cs_n,
	output logic             flash_rst_n,
	output logic [3:0]       flash_io_line_o,
	output logic [3:0]       flash_io_line_oe,
	input  wire logic [3:0]  flash_io_line_i
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		sfxmc_pkg::sfxmc_state_t st;
		sfxmc_pkg::sfxmc_op_t    op;
		sfxmc_pkg::sfxmc_seg_t   seg;
		logic [1:0]              frame;
		logic [5:0]              beats;
		logic [7:0]              dcnt;
		logic [31:0]             tx;
		logic [7:0]              rx;
		logic [7:0]              rdata;
		logic [2:0]              lw;
		logic [2:0]              oplw;
		logic                    exit_bit;
		logic                    dfirst;
		logic                    eip_on;
		logic                    armed;
		logic                    cs_n;
		logic                    rst_n;
		logic [3:0]              io_o;
		logic [3:0]              io_oe;
		logic [3:0]              s1;
		logic [3:0]              s2;
	} sfxmc_top_t;

	localparam sfxmc_top_t TOP_RST = '{st: sfxmc_pkg::ST_BOOT, op: sfxmc_pkg::OP_NOP,
		seg: sfxmc_pkg::SG_OPC, cs_n: 1'b1, rst_n: 1'b1, default: '0};

	sfxmc_top_t r;
	sfxmc_top_t n;
	logic       end_frame;
	logic       rise;
	logic       fall;

	sfxmc_core_if cif ();

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] lanes(input logic [1:0] w);
		case (w)
			2'h0:    return 3'd1;
			2'h1:    return 3'd2;
			default: return 3'd4;
		endcase
	endfunction

	function automatic logic [5:0] beats_for(input logic [5:0] bits, input logic [2:0] lw);
		case (lw)
			3'd1:    return bits;
			3'd2:    return bits >> 1;
			default: return bits >> 2;
		endcase
	endfunction

	function automatic logic [7:0] rd_opcode(input logic [2:0] lw);
		case (lw)
			3'd1:    return sfxmc_pkg::OPC_FREAD_1;
			3'd2:    return sfxmc_pkg::OPC_FREAD_2;
			default: return sfxmc_pkg::OPC_FREAD_4;
		endcase
	endfunction

	function automatic logic [1:0] last_frame(input sfxmc_pkg::sfxmc_op_t op);
		case (op)
			sfxmc_pkg::OP_ARM:    return 2'd1;
			sfxmc_pkg::OP_EXIT3:  return 2'd2;
			sfxmc_pkg::OP_PWRFIX: return 2'd3;
			default:              return 2'd0;
		endcase
	endfunction

	function automatic logic [5:0] burst_len(input logic [1:0] frame);
		case (frame)
			2'd0:    return sfxmc_pkg::BURST_A;
			2'd1:    return sfxmc_pkg::BURST_B;
			2'd2:    return sfxmc_pkg::BURST_C;
			default: return sfxmc_pkg::BURST_PWR;
		endcase
	endfunction

	function automatic logic [7:0] take(input logic [7:0] rx, input logic [3:0] s, input logic [2:0] lw);
		case (lw)
			3'd1:    return {rx[6:0], s[1]};
			3'd2:    return {rx[5:0], s[1:0]};
			default: return {rx[3:0], s};
		endcase
	endfunction

	// returns {enable, level} for io lines 3..0
	function automatic logic [7:0] pin_drive(input sfxmc_top_t s);
		logic [3:0] o;
		logic [3:0] oe;
		o = 4'h0;
		oe = 4'h0;
		if (!s.cs_n)
		begin
			case (s.seg)
				sfxmc_pkg::SG_OPC, sfxmc_pkg::SG_ADDR:
					case (s.lw)
						3'd1:
						begin
							o = {2'b11, 1'b0, s.tx[31]};
							oe = 4'hd;
						end
						3'd2:
						begin
							o = {2'b11, s.tx[31:30]};
							oe = 4'hf;
						end
						default:
						begin
							o = s.tx[31:28];
							oe = 4'hf;
						end
					endcase
				sfxmc_pkg::SG_DUMMY:
					if (s.dfirst)
					begin
						o = {3'b000, s.exit_bit};
						oe = 4'h1;
					end
				sfxmc_pkg::SG_BURST:
				begin
					o = {(s.op == sfxmc_pkg::OP_PWRFIX) && (s.frame == 2'd3), 3'b001};
					oe = o;
				end
				default:
					oe = 4'h0;
			endcase
		end
		return {oe, o};
	endfunction

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		n = r;
		end_frame = 1'b0;
		n.s1 = flash_io_line_i;
		n.s2 = r.s1;
		case (r.st)
			sfxmc_pkg::ST_BOOT:
			begin
				n.op = RST_PIN_USED ? sfxmc_pkg::OP_RSTPIN : sfxmc_pkg::OP_EXIT3;
				n.frame = 2'd0;
				n.dcnt = sfxmc_pkg::RST_PULSE_CYC;
				n.rst_n = !RST_PIN_USED;
				n.st = RST_PIN_USED ? sfxmc_pkg::ST_RSTP : sfxmc_pkg::ST_LOAD;
			end
			sfxmc_pkg::ST_IDLE:
				if (cif.go)
				begin
					n.op = cif.op;
					n.frame = 2'd0;
					n.oplw = lanes(cif.width);
					n.exit_bit = cif.exit_req;
					n.dcnt = sfxmc_pkg::RST_PULSE_CYC;
					case (cif.op)
						sfxmc_pkg::OP_ARM, sfxmc_pkg::OP_READ, sfxmc_pkg::OP_EXIT3, sfxmc_pkg::OP_PWRFIX:
							n.st = sfxmc_pkg::ST_LOAD;
						sfxmc_pkg::OP_RSTPIN:
							if (RST_PIN_USED)
							begin
								n.rst_n = 1'b0;
								n.st = sfxmc_pkg::ST_RSTP;
							end
						default:
							n.st = sfxmc_pkg::ST_IDLE;
					endcase
				end
			sfxmc_pkg::ST_LOAD:
			begin
				n.cs_n = 1'b0;
				n.dfirst = 1'b0;
				n.st = sfxmc_pkg::ST_SHIFT;
				n.lw = 3'd1;
				n.beats = sfxmc_pkg::BYTE_BITS;
				case (r.op)
					sfxmc_pkg::OP_ARM:
					begin
						n.seg = sfxmc_pkg::SG_OPC;
						n.tx = {(r.frame == 2'd0) ? sfxmc_pkg::OPC_WR_ENABLE : sfxmc_pkg::OPC_WR_VOLCFG, 24'h0};
					end
					sfxmc_pkg::OP_READ:
						if (r.eip_on)
						begin
							n.seg = sfxmc_pkg::SG_ADDR;
							n.tx = {cif.addr, 8'h00};
							n.lw = r.oplw;
							n.beats = beats_for(sfxmc_pkg::ADDR_BITS, r.oplw);
						end
						else
						begin
							n.seg = sfxmc_pkg::SG_OPC;
							n.tx = {rd_opcode(r.oplw), 24'h0};
						end
					default:
					begin
						n.seg = sfxmc_pkg::SG_BURST;
						n.tx = 32'h0;
						n.beats = burst_len(r.frame);
					end
				endcase
			end
			sfxmc_pkg::ST_SHIFT:
			begin
				if (rise && (r.seg == sfxmc_pkg::SG_DATA))
					n.rx = take(r.rx, r.s2, r.lw);
				if (fall)
				begin
					if (r.beats != 6'd1)
					begin
						n.beats = r.beats - 6'd1;
						n.tx = r.tx << r.lw;
						n.dfirst = 1'b0;
					end
					else
					begin
						case (r.seg)
							sfxmc_pkg::SG_OPC:
								if (r.op == sfxmc_pkg::OP_READ)
								begin
									n.seg = sfxmc_pkg::SG_ADDR;
									n.tx = {cif.addr, 8'h00};
									n.lw = r.oplw;
									n.beats = beats_for(sfxmc_pkg::ADDR_BITS, r.oplw);
								end
								else if ((r.op == sfxmc_pkg::OP_ARM) && (r.frame == 2'd1))
								begin
									n.seg = sfxmc_pkg::SG_ADDR;
									n.tx = {cif.vol_cfg, 24'h0};
									n.beats = sfxmc_pkg::BYTE_BITS;
								end
								else
									end_frame = 1'b1;
							sfxmc_pkg::SG_ADDR:
								if (r.op == sfxmc_pkg::OP_READ)
								begin
									n.seg = sfxmc_pkg::SG_DUMMY;
									n.dfirst = 1'b1;
									n.beats = {2'b00, (cif.dummy == 4'h0) ? 4'h1 : cif.dummy};
								end
								else
									end_frame = 1'b1;
							sfxmc_pkg::SG_DUMMY:
							begin
								n.seg = sfxmc_pkg::SG_DATA;
								n.dfirst = 1'b0;
								n.beats = beats_for(sfxmc_pkg::BYTE_BITS, r.lw);
							end
							default:
								end_frame = 1'b1;
						endcase
					end
				end
			end
			sfxmc_pkg::ST_DESEL:
				if (r.dcnt == 8'd1)
				begin
					if (r.frame == last_frame(r.op))
					begin
						n.st = sfxmc_pkg::ST_IDLE;
						n.seg = sfxmc_pkg::SG_OPC;
						if ((r.op == sfxmc_pkg::OP_EXIT3) || (r.op == sfxmc_pkg::OP_PWRFIX))
							n.eip_on = 1'b0;
						if (r.op == sfxmc_pkg::OP_PWRFIX)
							n.armed = 1'b0;
					end
					else
					begin
						n.frame = r.frame + 2'd1;
						n.st = sfxmc_pkg::ST_LOAD;
					end
				end
				else
					n.dcnt = r.dcnt - 8'd1;
			sfxmc_pkg::ST_RSTP:
				if (r.dcnt == 8'd1)
				begin
					n.rst_n = 1'b1;
					n.eip_on = 1'b0;
					n.armed = 1'b0;
					n.st = sfxmc_pkg::ST_DESEL;
					n.dcnt = sfxmc_pkg::DESEL_CYC;
				end
				else
					n.dcnt = r.dcnt - 8'd1;
			default:
				n.st = sfxmc_pkg::ST_IDLE;
		endcase
		if (end_frame)
		begin
			n.cs_n = 1'b1;
			n.st = sfxmc_pkg::ST_DESEL;
			n.dcnt = sfxmc_pkg::DESEL_CYC;
			if (r.seg == sfxmc_pkg::SG_DATA)
			begin
				n.rdata = r.rx;
				n.eip_on = !r.exit_bit && (r.armed || cif.basic);
			end
			if ((r.op == sfxmc_pkg::OP_ARM) && (r.frame == 2'd1))
				n.armed = !cif.vol_cfg[sfxmc_pkg::VOLCFG_EIP_BIT];
		end
		{n.io_oe, n.io_o} = pin_drive(n);
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			r <= TOP_RST;
		else
			r <= n;
	end

	// ------------------------------------------------------------
	// outputs and instances
	// ------------------------------------------------------------
	assign cif.busy         = (r.st != sfxmc_pkg::ST_IDLE);
	assign cif.eip_on       = r.eip_on;
	assign cif.armed        = r.armed;
	assign cif.rdata        = r.rdata;
	assign flash_cs_n       = r.cs_n;
	assign flash_rst_n      = r.rst_n;
	assign flash_io_line_o  = r.io_o;
	assign flash_io_line_oe = r.io_oe;

	sfxmc_apb_regs u_regs
	(
		.clk     (clk),
		.nrst    (nrst),
		.paddr   (paddr),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.cif     (cif.regs)
	);

	sfxmc_sclk_div u_div
	(
		.clk  (clk),
		.nrst (nrst),
		.run  (r.st == sfxmc_pkg::ST_SHIFT),
		.sclk (flash_sclk),
		.rise (rise),
		.fall (fall)
	);
endmodule // sfxmc_top

// ---- sfxmc_props.sv ----
// Purpose: assertions on the controller pins
// Assumes: one clock domain
// Notes: bound into sfxmc_top
`timescale 1ns/1ps
module sfxmc_props
#(
	parameter bit RST_PIN_USED = 1'b0
)
(
	// clock and reset
	input	wire logic		clk,
	input	wire logic		nrst,
	// apb
	input	wire logic		psel,
	input	wire logic		penable,
	input	wire logic		pslverr,
	// flash pins
	input	wire logic		flash_sclk,
	input	wire logic		flash_cs_n,
	input	wire logic		flash_rst_n,
	input	wire logic [3:0]	flash_io_line_o,
	input	wire logic [3:0]	flash_io_line_oe
);
	// ----
	// checks
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence hi_beat;
		flash_sclk [*4] ##1 !flash_sclk;
	endsequence
	sequence lo_beat;
		!flash_sclk [*4] ##1 flash_sclk;
	endsequence
	sclk_high_a: assert property ($rose(flash_sclk) |-> hi_beat)
		else $error("sclk high time");
	first_rise_a: assert property ($fell(flash_cs_n) |-> lo_beat)
		else $error("first sclk rise");
	sclk_low_a: assert property ($fell(flash_sclk) && !flash_cs_n |-> lo_beat)
		else $error("sclk low time");
	idle_pins_a: assert property (flash_cs_n |-> !flash_sclk && flash_io_line_oe == 4'h0)
		else $error("idle pins");
	desel_time_a: assert property ($rose(flash_cs_n) |-> flash_cs_n [*5])
		else $error("deselect short");
	io_hold_a: assert property (flash_sclk |-> $stable(flash_io_line_o) && $stable(flash_io_line_oe))
		else $error("io moved");
	boot_exit_a: assert property ($rose(nrst) && !RST_PIN_USED |->
		##[0:8] (!flash_cs_n && flash_io_line_o[0] && flash_io_line_oe[0]))
		else $error("no boot burst");
	rst_pin_a: assert property (!RST_PIN_USED |-> flash_rst_n)
		else $error("reset pin moved");
	slverr_when_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
endmodule // sfxmc_props
bind sfxmc_top sfxmc_props #(.RST_PIN_USED(RST_PIN_USED)) sfxmc_props_i (.clk, .nrst, .psel, .penable,
	.pslverr, .flash_sclk, .flash_cs_n, .flash_rst_n, .flash_io_line_o, .flash_io_line_oe);

// ---- sfxmc_flash_model.sv ----
// Purpose: flash device model, single-line frames
// Assumes: mode 0 clock, pull-ups on io lines
// Notes: array byte is address low byte xor 5a
`timescale 1ns/1ps
module sfxmc_flash_model
#(
	parameter int DUMMY = 8
)
(
	// flash pins
	input	wire logic		sclk,
	input	wire logic		cs_n,
	input	wire logic [3:0]	io,
	// device variant: enters without arming
	input	wire logic		basic,
	// model drive
	output	logic [3:0]		drv_o,
	output	logic [3:0]		drv_oe
);
	// ----
	// frame decode
	// ----
	logic [47:0]	sh;
	logic [7:0]	op, dat;
	logic		write_enable_latch = 1'b0, armed = 1'b0, execute_in_place = 1'b0, fixd = 1'b0, cf = 1'b1, hi0, hi3;
	int		n = 0, bst = 0, ds;
	assign ds = execute_in_place ? 24 + DUMMY : 32 + DUMMY;
	initial drv_oe = 4'h0;
	initial drv_o = 4'h0;
	always @(negedge cs_n)
	begin
		n = 0;
		op = 8'h00;
		hi0 = 1'b1;
		hi3 = 1'b1;
	end
	// io line 0 gives the confirmation bit in the first dummy cycle; io line 3 is sampled on every clock too
	always @(posedge sclk) if (!cs_n)
	begin
		sh = {sh[46:0], io[0]};
		hi0 &= io[0];
		hi3 &= io[3];
		n++;
		if (n == 8) op = sh[7:0];
		if (n == ds - DUMMY + 1) cf = io[0];
	end
	always @(negedge sclk) if (!cs_n && (execute_in_place || op == 8'h0b) && n >= ds && n < ds + 8)
	begin
		if (n == ds) dat = sh[DUMMY +: 8] ^ 8'h5a;
		drv_oe = 4'h2;
		drv_o = {2'h0, dat[7 - (n - ds)], 1'b0};
	end
	always @(posedge cs_n)
	begin
		drv_oe = 4'h0;
		if (hi0 && hi3 && n == 8 && bst == 3)
		begin
			fixd = 1'b1;
			armed = 1'b0;
		end
		if (hi0 && n == 7) bst = 1;
		else if (hi0 && n == 13 && bst == 1) bst = 2;
		else if (hi0 && n == 25 && bst == 2)
		begin
			bst = 3;
			execute_in_place = 1'b0;
		end
		else bst = 0;
		if (op == 8'h06 && n == 8) write_enable_latch = 1'b1;
		else if (op == 8'h81 && n == 16)
		begin
			if (write_enable_latch) armed = !sh[3] && !fixd;
			write_enable_latch = 1'b0;
		end
		else if ((execute_in_place || op == 8'h0b) && n >= ds + 8) execute_in_place = (armed | basic) & !cf;
	end
endmodule // sfxmc_flash_model

// ---- tb_sfxmc_top.sv ----
// Purpose: self-checking bench of the flash host controller
// Assumes: no flash reset pin, single-line frames
// Notes: frame lengths are counted in flash clocks
`timescale 1ns/1ps
module tb_sfxmc_top;
	logic		clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bas = 1'b0;
	logic [7:0]	paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0, prdata, r;
	logic		pready, pslverr, sclk, cs_n, rst_n, e;
	logic [3:0]	io_o, io_oe, m_o, m_oe, io_w;
	logic [23:0]	a;
	int		err_count = 0, compares = 0, seed = 54358, fn = 0, fq[$], exp_arm = 0, exp_eip = 0;
	// released lines float high
	assign io_w = (io_o & io_oe) | (m_o & m_oe) | ~(io_oe | m_oe);
	sfxmc_top sfxmc_top_i (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash_sclk(sclk), .flash_cs_n(cs_n), .flash_rst_n(rst_n), .flash_io_line_o(io_o),
		.flash_io_line_oe(io_oe), .flash_io_line_i(io_w));
	sfxmc_flash_model sfxmc_flash_model_i (.sclk(sclk), .cs_n(cs_n), .io(io_w), .basic(bas), .drv_o(m_o),
		.drv_oe(m_oe));
	initial forever #5 clk = ~clk;
	always @(negedge cs_n) fn = 0;
	always @(posedge sclk) if (!cs_n) fn++;
	always @(posedge cs_n) if (nrst) fq.push_back(fn);
	// ----
	// tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x)
		begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= ad;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic idle();
		do apb(sfxmc_pkg::ADDR_STATUS, 1'b0, 32'h0); while (r[0] !== 1'b0);
	endtask
	task automatic run(input logic [2:0] o);
		fq.delete();
		apb(sfxmc_pkg::ADDR_CTRL, 1'b1, 32'h10 | 32'(o));
		repeat (4) @(posedge clk);
		idle();
	endtask
	task automatic chk_q(input int x[$]);
		chk("frames", 32'(x.size()), 32'(fq.size()));
		foreach (x[i]) chk("frame len", 32'(x[i]), 32'(fq[i]));
	endtask
	task automatic st(input int t);
		apb(sfxmc_pkg::ADDR_STATUS, 1'b0, 32'h0);
		chk("status", 32'(exp_arm * 4 + exp_eip * 2), r);
		$display("test %0d done", t);
	endtask
	// address only frame is 40 clocks, opcode frame 48
	task automatic rd(input logic cf, input int t);
		a = 24'($random(seed));
		apb(sfxmc_pkg::ADDR_FADDR, 1'b1, 32'(a));
		apb(sfxmc_pkg::ADDR_CFG, 1'b1, 32'h80 | (32'(cf) << 9) | (32'(bas) << 8));
		run(3'h2);
		chk_q('{exp_eip ? 40 : 48});
		apb(sfxmc_pkg::ADDR_RDATA, 1'b0, 32'h0);
		chk("rdata", 32'(a[7:0] ^ 8'h5a), r);
		exp_eip = int'(!cf) & (exp_arm | int'(bas));
		st(t);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#500000;
		err_count++;
		print_verdict();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		idle();
		chk_q('{7, 13, 25});
		st(1);
		apb(sfxmc_pkg::ADDR_CFG, 1'b0, 32'h0);
		chk("cfg", 32'h80, r);
		apb(sfxmc_pkg::ADDR_VOLCFG, 1'b0, 32'h0);
		chk("volcfg", 32'hf7, r);
		apb(8'h18, 1'b0, 32'h0);
		chk("unmapped", 32'h1, r | 32'(e));
		rd(1'b0, 2);
		bas = 1'b1;
		rd(1'b0, 12);
		rd(1'b1, 13);
		bas = 1'b0;
		run(3'h1);
		chk_q('{8, 16});
		exp_arm = 1;
		st(3);
		rd(1'b0, 4);
		rd(1'b0, 5);
		rd(1'b1, 6);
		rd(1'b0, 7);
		run(3'h3);
		chk_q('{7, 13, 25});
		exp_eip = 0;
		st(8);
		rd(1'b0, 9);
		run(3'h4);
		chk_q('{7, 13, 25, 8});
		exp_arm = 0;
		exp_eip = 0;
		st(10);
		rd(1'b0, 11);
		run(3'h5);
		chk("rst frames", 32'h0, 32'(fq.size()));
		chk("rst pin", 32'h1, 32'(rst_n));
		// second reset in mid-run: rescue bursts must follow again
		fq.delete();
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		idle();
		chk_q('{7, 13, 25});
		st(14);
		print_verdict();
	end
endmodule // tb_sfxmc_top
